/* rtl/mrx_instr_exec.sv */
// Execution unit for store, load-literal, idle, move-file and return instructions.
// Assumes the fetch stage presents the word and the file data read at its operand.
`timescale 1ns/10ps
module mrx_instr_exec (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  instr_valid,
  input  wire logic [mrx_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [mrx_pkg::DATA_W-1:0]  file_rd_data,
  input  wire logic                  call_push,
  input  wire logic [mrx_pkg::PC_W-1:0]    call_addr,
  input  wire logic                  irq_taken,
  output logic                       instr_busy,
  output logic [mrx_pkg::PC_W-1:0]   program_counter,
  output logic [mrx_pkg::DATA_W-1:0] acc_value,
  output logic                       zero_flag,
  output logic                       global_irq_enable,
  output logic                       file_wr_en,
  output logic [mrx_pkg::FADDR_W-1:0] file_wr_addr,
  output logic [mrx_pkg::DATA_W-1:0] file_wr_data
);
  import mrx_pkg::*;

  // ===========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n_sync;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // ===========================================================================
  // Decode
  mrx_state_type       state_reg;
  mrx_state_type       state_next;
  logic                busy_reg;
  logic [PC_W-1:0]     pc_reg;
  logic [PC_W-1:0]     pc_next;
  logic [DATA_W-1:0]   acc_reg;
  logic [DATA_W-1:0]   acc_next;
  logic                zero_reg;
  logic                zero_next;
  logic [7:0]          irq_control_reg;
  logic [7:0]          irq_control_next;
  logic                wr_en_reg;
  logic                wr_en_next;
  logic [FADDR_W-1:0]  wr_addr_reg;
  logic [FADDR_W-1:0]  wr_addr_next;
  logic [DATA_W-1:0]   wr_data_reg;
  logic [DATA_W-1:0]   wr_data_next;
  logic [PC_W-1:0]     stack_top;

  wire               accept       = instr_valid && state_reg == MRX_EXEC;
  wire               is_store     = (instr_word & STORE_ACC_MASK) == STORE_ACC_CODE;
  wire               is_load_lit  = (instr_word & LOAD_LIT_MASK) == LOAD_LIT_CODE;
  wire               is_lit_ret   = (instr_word & LOAD_LIT_MASK) == LIT_RET_CODE;
  wire               is_file_move = (instr_word & FILE_MOVE_MASK) == FILE_MOVE_CODE;
  wire               is_irq_ret   = instr_word == IRQ_RET_CODE;
  wire               is_sub_ret   = instr_word == SUB_RET_CODE;
  wire               is_return    = is_irq_ret || is_lit_ret || is_sub_ret;
  wire               stack_pop    = accept && is_return;
  wire [DATA_W-1:0]  literal      = instr_word[DATA_W-1:0];
  wire [FADDR_W-1:0] file_addr    = instr_word[FADDR_W-1:0];
  wire [PC_W-1:0]    pc_inc       = PC_W'(pc_reg + PC_STEP);

  // Unknown words fall through as idle so a bad fetch cannot hang the core
  always_comb begin
    state_next   = MRX_EXEC;
    pc_next      = pc_reg;
    acc_next     = acc_reg;
    zero_next    = zero_reg;
    wr_en_next   = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    if (accept) begin
      if (is_store) begin
        wr_en_next   = 1'b1;
        wr_addr_next = file_addr;
        wr_data_next = acc_reg;
        pc_next      = pc_inc;
      end else if (is_load_lit) begin
        acc_next = literal;
        pc_next  = pc_inc;
      end else if (is_file_move) begin
        zero_next = file_rd_data == '0;
        pc_next   = pc_inc;
        if (instr_word[DEST_BIT]) begin
          wr_en_next   = 1'b1;
          wr_addr_next = file_addr;
          wr_data_next = file_rd_data;
        end else begin
          acc_next = file_rd_data;
        end
      end else if (is_return) begin
        pc_next    = stack_top;
        state_next = MRX_FLUSH;
        if (is_lit_ret) begin
          acc_next = literal;
        end
      end else begin
        pc_next = pc_inc;
      end
    end
  end

  // Set by the return wins over a same-cycle clear from interrupt entry
  always_comb begin
    irq_control_next = irq_control_reg;
    if (irq_taken) begin
      irq_control_next[IRQ_EN_BIT] = 1'b0;
    end
    if (accept && is_irq_ret) begin
      irq_control_next[IRQ_EN_BIT] = 1'b1;
    end
  end

  // ===========================================================================
  // State
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg       <= MRX_EXEC;
      busy_reg        <= 1'b0;
      pc_reg          <= PC_RESET;
      acc_reg         <= ACC_RESET;
      zero_reg        <= 1'b0;
      irq_control_reg <= IRQCTL_RESET;
      wr_en_reg       <= 1'b0;
      wr_addr_reg     <= '0;
      wr_data_reg     <= '0;
    end else begin
      state_reg       <= state_next;
      busy_reg        <= state_next == MRX_FLUSH;
      pc_reg          <= pc_next;
      acc_reg         <= acc_next;
      zero_reg        <= zero_next;
      irq_control_reg <= irq_control_next;
      wr_en_reg       <= wr_en_next;
      wr_addr_reg     <= wr_addr_next;
      wr_data_reg     <= wr_data_next;
    end
  end

  mrx_return_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (PC_W)
  ) u_stack (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_sync),
    .push      (call_push),
    .pop       (stack_pop),
    .push_addr (call_addr),
    .stack_top (stack_top)
  );

  assign instr_busy        = busy_reg;
  assign program_counter   = pc_reg;
  assign acc_value         = acc_reg;
  assign zero_flag         = zero_reg;
  assign global_irq_enable = irq_control_reg[IRQ_EN_BIT];
  assign file_wr_en        = wr_en_reg;
  assign file_wr_addr      = wr_addr_reg;
  assign file_wr_data      = wr_data_reg;

  // ===========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_ret_taken;
    accept && is_return;
  endsequence
  sequence s_two_cycle;
    instr_busy ##1 !instr_busy;
  endsequence

  property p_store;
    accept && is_store |=> file_wr_en && file_wr_addr == $past(file_addr)
      && file_wr_data == $past(acc_reg) && $stable(acc_value) && $stable(zero_flag);
  endproperty
  a_store: assert property (p_store) else $error("store result wrong");

  property p_load;
    accept && is_load_lit |=> acc_value == $past(literal) && $stable(zero_flag) && !file_wr_en;
  endproperty
  a_load: assert property (p_load) else $error("load literal wrong");

  property p_dont_care;
    accept && instr_word[13:8] == 6'h30 |=> acc_value == $past(literal);
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("zero-coded load rejected");

  property p_irq_pop;
    accept && is_irq_ret |=> program_counter == $past(stack_top);
  endproperty
  a_irq_pop: assert property (p_irq_pop) else $error("irq return pc wrong");

  property p_irq_enable;
    accept && is_irq_ret |=> global_irq_enable;
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("irq enable not set");

  property p_irq_two;
    accept && is_irq_ret |=> s_two_cycle and $stable(zero_flag) [*2];
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("irq return timing");

  property p_lit_ret;
    accept && is_lit_ret |=> acc_value == $past(literal) && program_counter == $past(stack_top);
  endproperty
  a_lit_ret: assert property (p_lit_ret) else $error("literal return wrong");

  property p_lit_two;
    s_ret_taken and is_lit_ret |=> s_two_cycle and $stable(zero_flag) [*2];
  endproperty
  a_lit_two: assert property (p_lit_two) else $error("literal return timing");

  property p_sub_ret;
    accept && is_sub_ret |=> program_counter == $past(stack_top) && $stable(acc_value)
      ##0 s_two_cycle;
  endproperty
  a_sub_ret: assert property (p_sub_ret) else $error("subroutine return wrong");

  property p_single;
    accept && (is_store || is_load_lit || (instr_word & IDLE_MASK) == IDLE_CODE)
      |=> !instr_busy && program_counter == PC_W'($past(pc_reg) + PC_STEP);
  endproperty
  a_single: assert property (p_single) else $error("single cycle op wrong");

  property p_move;
    accept && is_file_move |=> zero_flag == ($past(file_rd_data) == '0)
      && file_wr_en == $past(instr_word[DEST_BIT]);
  endproperty
  a_move: assert property (p_move) else $error("file move wrong");

endmodule : mrx_instr_exec

/* rtl/mrx_pkg.sv */
// Constants for the move and return instruction execution unit.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package mrx_pkg;

  // ===========================================================================
  // Widths
  localparam int INSTR_W     = 14;
  localparam int PC_W        = 13;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int STACK_DEPTH = 8;

  // ===========================================================================
  // Opcode masks and codes
  localparam logic [13:0] STORE_ACC_MASK = 14'h3F80;
  localparam logic [13:0] STORE_ACC_CODE = 14'h0080;
  localparam logic [13:0] LOAD_LIT_MASK  = 14'h3C00;
  localparam logic [13:0] LOAD_LIT_CODE  = 14'h3000;
  localparam logic [13:0] LIT_RET_CODE   = 14'h3400;
  localparam logic [13:0] FILE_MOVE_MASK = 14'h3F00;
  localparam logic [13:0] FILE_MOVE_CODE = 14'h0800;
  localparam logic [13:0] IDLE_MASK      = 14'h3F9F;
  localparam logic [13:0] IDLE_CODE      = 14'h0000;
  localparam logic [13:0] IRQ_RET_CODE   = 14'h0009;
  localparam logic [13:0] SUB_RET_CODE   = 14'h0008;

  // ===========================================================================
  // Field positions
  localparam int DEST_BIT = 7;
  localparam int IRQ_EN_BIT = 7;

  // ===========================================================================
  // Reset values
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  IRQCTL_RESET = 8'h00;
  localparam logic [12:0] PC_STEP      = 13'h0001;

  typedef enum logic {
    MRX_EXEC  = 1'b0,
    MRX_FLUSH = 1'b1
  } mrx_state_type;

endpackage : mrx_pkg

/* rtl/mrx_return_stack.sv */
// Circular hardware return stack holding program counter values.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/10ps
module mrx_return_stack #(
  parameter int DEPTH = mrx_pkg::STACK_DEPTH,
  parameter int AW    = mrx_pkg::PC_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_addr,
  output logic      [AW-1:0] stack_top
);
  import mrx_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [PW-1:0] ptr_reg;
  logic [PW-1:0] ptr_next;
  logic [AW-1:0] mem_reg [DEPTH];
  wire  [PW-1:0] top_idx   = PW'(ptr_reg - 1'b1);
  wire  [PW-1:0] write_idx = pop ? top_idx : ptr_reg;

  // Overflow wraps silently, as the stack has no status
  assign ptr_next  = (push && !pop) ? PW'(ptr_reg + 1'b1) :
                     (pop && !push) ? top_idx : ptr_reg;
  assign stack_top = mem_reg[top_idx];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // ===========================================================================
  // Entries
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge sys_clk) begin
        if (push && write_idx == PW'(i)) begin
          mem_reg[i] <= push_addr;
        end
      end
    end
  endgenerate

endmodule : mrx_return_stack

/* bench/tb_top.sv */
// Self-checking bench for the move and return execution unit.
// Assumes the design checks its own rules with in-file assertions.
`timescale 1ns/10ps
module tb_top;
  import mrx_pkg::*;
  logic                 sys_clk, reset_n, instr_valid, call_push, irq_taken;
  logic [INSTR_W-1:0]   instr_word;
  logic [DATA_W-1:0]    file_rd_data, acc_value, file_wr_data;
  logic [PC_W-1:0]      call_addr, program_counter;
  logic [FADDR_W-1:0]   file_wr_addr;
  logic                 instr_busy, zero_flag, global_irq_enable, file_wr_en, take_now;
  logic [39:0]          exp_q[$];
  logic [PC_W-1:0]      stk[8];
  logic [2:0]           sp;
  logic [PC_W-1:0]      m_pc;
  logic [7:0]           m_acc, m_data;
  logic [6:0]           m_addr;
  logic                 m_z, m_irq_en;
  int                   num_errors, checks_done;

  mrx_instr_exec u_mrx_instr_exec (.sys_clk(sys_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .file_rd_data(file_rd_data),
    .call_push(call_push), .call_addr(call_addr), .irq_taken(irq_taken),
    .instr_busy(instr_busy), .program_counter(program_counter), .acc_value(acc_value),
    .zero_flag(zero_flag), .global_irq_enable(global_irq_enable),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

  // ===========================================================================
  // Clock, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  task automatic final_report();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ===========================================================================
  // Monitor: one note per accepted word, compared when its result lands
  always @(posedge sys_clk) begin
    take_now <= instr_valid && !instr_busy;
  end

  always @(negedge sys_clk) begin : monitor_cmp
    logic [39:0] got, e;
    if (take_now) begin
      got = {instr_busy, file_wr_en, global_irq_enable, zero_flag, acc_value,
             program_counter, file_wr_addr, file_wr_data};
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'h00_0000_0000;
      checks_done++;
      if (got !== e) begin
        num_errors++;
        $display("unexpected state at %0t: got %h expected %h", $time, got, e);
      end
    end
  end

  // ===========================================================================
  // Driver with reference model
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic irq);
    logic wr, ret;
    wr = 1'b0;
    ret = 1'b0;
    if (irq) m_irq_en = 1'b0;
    if ((w & STORE_ACC_MASK) == STORE_ACC_CODE) begin
      wr = 1'b1;
      m_addr = w[6:0];
      m_data = m_acc;
    end else if ((w & LOAD_LIT_MASK) == LOAD_LIT_CODE) begin
      m_acc = w[7:0];
    end else if ((w & LOAD_LIT_MASK) == LIT_RET_CODE) begin
      ret = 1'b1;
      m_acc = w[7:0];
    end else if ((w & FILE_MOVE_MASK) == FILE_MOVE_CODE) begin
      m_z = (rd == 8'h00);
      if (w[DEST_BIT]) begin
        wr = 1'b1;
        m_addr = w[6:0];
        m_data = rd;
      end else begin
        m_acc = rd;
      end
    end else if (w == IRQ_RET_CODE) begin
      ret = 1'b1;
      m_irq_en = 1'b1;
    end else if (w == SUB_RET_CODE) begin
      ret = 1'b1;
    end
    if (ret) begin
      sp = sp - 3'h1;
      m_pc = stk[sp];
    end else begin
      m_pc = m_pc + PC_STEP;
    end
    exp_q.push_back({ret, wr, m_irq_en, m_z, m_acc, m_pc, m_addr, m_data});
    instr_valid = 1'b1;
    instr_word = w;
    file_rd_data = rd;
    irq_taken = irq;
    call_push = 1'b0;
    tick();
    if (ret) begin
      // Busy cycle: a store offered now must leave no trace
      instr_word = STORE_ACC_CODE | {7'h00, 7'($urandom)};
      irq_taken = 1'b0;
      tick();
    end
  endtask : issue

  task automatic push_n(input int n);
    instr_valid = 1'b0;
    irq_taken = 1'b0;
    call_push = 1'b1;
    for (int i = 0; i < n; i++) begin
      call_addr = 13'($urandom);
      stk[sp] = call_addr;
      sp = sp + 3'h1;
      tick();
    end
    call_push = 1'b0;
  endtask : push_n

  // ===========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    {instr_valid, call_push, irq_taken} = 3'h0;
    instr_word = 14'h0000;
    file_rd_data = 8'h00;
    call_addr = 13'h0000;
    reset_n = 1'b0;
    {m_pc, m_acc, m_data, m_addr, m_z, m_irq_en, sp} = '0;
    void'($urandom(32'h8b4d));
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) tick();
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      issue(LOAD_LIT_CODE | {4'h0, r[9:8], r[7:0]}, 8'h00, 1'b0);
      issue(STORE_ACC_CODE | {7'h00, (i < 2) ? 7'(i * 127) : r[22:16]}, 8'h00, 1'b0);
      issue(IDLE_CODE | {7'h00, r[11:10], 5'h00}, r[31:24], 1'b0);
      issue(FILE_MOVE_CODE | {6'h00, r[12], r[22:16]}, (i % 4 == 0) ? 8'h00 : r[31:24],
            1'b0);
    end
    // Nine pushes wrap the eight-deep stack; returns run back to back
    push_n(9);
    for (int i = 0; i < 9; i++) begin
      r = $urandom;
      case (i % 3)
        0: issue(LIT_RET_CODE | {4'h0, r[9:8], r[7:0]}, 8'h00, 1'b0);
        1: issue(IRQ_RET_CODE, 8'h00, r[0]);
        default: issue(SUB_RET_CODE, 8'h00, 1'b0);
      endcase
    end
    issue(LOAD_LIT_CODE | 14'h00a5, 8'h00, 1'b1);
    push_n(1);
    issue(IRQ_RET_CODE, 8'h00, 1'b1);
    issue(STORE_ACC_CODE | 14'h007f, 8'h00, 1'b0);
    instr_valid = 1'b0;
    repeat (3) tick();
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("unexpected leftover at %0t: got %h expected %h", $time, exp_q.size(), 0);
    end
    final_report();
  end
endmodule : tb_top
